// >>> rtl/tb_timer_cfg.svh
`ifndef TB_TIMER_CFG_SVH
`define TB_TIMER_CFG_SVH
`define OFS_CONTROL      12'h000
`define OFS_SLAVE_MODE   12'h004
`define OFS_OPTION       12'h008
`define OFS_EVENT_GEN    12'h00C
`define OFS_FLAGS        12'h010
`define OFS_COUNT        12'h014
`define OFS_PRESCALE     12'h018
`define OFS_AUTO_RELOAD  12'h01C
`define OFS_CHAN_MODE    12'h020
`define OFS_CHAN_ENABLE  12'h024
`define ARR_RESET        16'hFFFF
`define SMS_INTERNAL     3'h0
`define SMS_EXT_CLOCK1   3'h7
`define TS_TRIG0         3'h0
`define TS_CHAN2         3'h6
`define ETPS_DIV1        2'h0
`define ETPS_DIV2        2'h1
`define ETPS_DIV4        2'h2
`define ETPS_DIV8        2'h3
`define SRC_PCLK         2'h0
`define SRC_RC1K         2'h1
`define SRC_32K          2'h2
`define SRC_PIN          2'h3
`define CMS_EDGE         2'h0
`endif

// >>> rtl/tb_timer_pkg.sv
package tb_timer_pkg;
   typedef struct packed {
      logic       auto_reload_buffer_enable;
      logic [1:0] center_mode;
      logic       count_direction;
      logic       update_request_source;
      logic       update_disable;
      logic       counter_enable;
   } timer_control_one_type;
   typedef struct packed {
      logic       ext_trigger_polarity;
      logic       ext_clock_enable;
      logic [1:0] ext_trigger_prescale;
      logic [3:0] ext_trigger_filter;
      logic [2:0] trigger_select;
      logic [2:0] slave_mode_select;
   } slave_mode_control_type;
   typedef struct packed {
      logic       clock_mask_enable;
      logic [1:0] ext_trigger_source_sel;
   } timer_option_type;
   typedef struct packed {
      logic       trigger_irq_flag;
      logic       update_irq_flag;
   } timer_irq_flags_type;
   typedef struct packed {
      logic       rc1k;
      logic       clk32k;
      logic       timer_clock_pin;
      logic       timer_mask_pin;
      logic       chan2_input;
      logic       internal_trigger_zero;
   } timer_pins_type;
endpackage

// >>> rtl/timer_time_base.sv
// Operation
// - Down mode: ARR to 0, reload, underflow
// - Down update: underflow or software
// - Update disable blocks all update events
// - Down software update reloads ARR, prescaler zero
// - Request source hides software update flag
// - Update sets flag, copies shadows
// - Down: new ARR used before reload
// - Center: 0 up ARR-1, ARR down 1
// - Center: direction driven by hardware only
// - Center: update both ends; software restarts zero
// - Center, disabled updates: keep active ARR
// - Center overflow: refresh ARR, then load
// - Clock from internal, channel, trigger, timer
// - Mode 000: internal clock, update bit self-clears
// - Internal: prescaler runs once enable written
// - Mode 111: count trigger edges; trigger 0 counts high cycles
// - Mode 1 edge counts, sets trigger flag
// - External clock enable selects mode 2
// - Source select: pclk, 1k, 32k, pin
// - Mask enable ANDs clock pin with mask
// - Trigger path: polarity, filter, prescaler
// - Up mode: 0 to ARR, overflow
// - Prescaler divides by two to exponent
// - Internal enable follows bit one cycle later
//
// Chosen here: the placing of the registers and the APB register port.
`include "tb_timer_cfg.svh"
module timer_time_base (
   // Clock and reset.
   input  wire logic                     SYS_CLK_IN,
   input  wire logic                     ARST_N_IN,
   // APB slave.
   input  wire logic                     PSEL_IN,
   input  wire logic                     PENABLE_IN,
   input  wire logic                     PWRITE_IN,
   input  wire logic [11:0]              PADDR_IN,
   input  wire logic [31:0]              PWDATA_IN,
   output logic      [31:0]              PRDATA_OUT,
   output logic                          PREADY_OUT,
   output logic                          PSLVERR_OUT,
   // External pins.
   input  wire tb_timer_pkg::timer_pins_type PINS_IN,
   // Events.
   output logic                          UPDATE_EVENT_OUT,
   output logic      [15:0]              COUNT_OUT
);
   logic                                 rst_a_reg;
   logic                                 rst_n_reg;
   logic [5:0]                           pin_a_reg;
   logic [5:0]                           pin_b_reg;
   tb_timer_pkg::timer_control_one_type  ctrl_reg;
   tb_timer_pkg::slave_mode_control_type smc_reg;
   tb_timer_pkg::timer_option_type       opt_reg;
   tb_timer_pkg::timer_irq_flags_type    flags_reg;
   logic [1:0]                           chan2_selection_reg;
   logic [3:0]                           chan2_input_filter_reg;
   logic                                 chan2_polarity_reg;
   logic [15:0]                          cnt_reg;
   logic [15:0]                          arr_buf_reg;
   logic [15:0]                          arr_act_reg;
   logic [3:0]                           psc_buf_reg;
   logic [3:0]                           psc_act_reg;
   logic [15:0]                          psc_cnt_reg;
   logic                                 run_en_reg;
   logic                                 up_dir_reg;
   logic                                 sw_update_reg;
   logic                                 sw_update_next;
   logic                                 ch2_filt_reg;
   logic                                 ch2_prev_reg;
   logic [3:0]                           ch2_run_reg;
   logic                                 trg_filt_reg;
   logic                                 trg_prev_reg;
   logic [3:0]                           trg_run_reg;
   logic [2:0]                           trg_div_reg;
   logic [31:0]                          rdata_next;
   logic                                 wr_en;
   logic                                 rd_en;
   logic                                 trg_raw;
   logic                                 trg_edge;
   logic                                 trg_tick;
   logic                                 ch2_edge;
   logic                                 ck_psc;
   logic                                 psc_done;
   logic                                 ck_cnt;
   logic                                 center;
   logic                                 going_up;
   logic                                 wrap;
   logic                                 update_ev;
   logic [15:0]                          psc_limit;
   logic [15:0]                          arr_eff;

   // Reset release through two flip-flops.
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rst_a_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_a_reg <= 1'b1;
         rst_n_reg <= rst_a_reg;
      end
   end

   // Pin synchronisers.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pin_a_reg <= 6'h00;
         pin_b_reg <= 6'h00;
      end else begin
         pin_a_reg <= PINS_IN;
         pin_b_reg <= pin_a_reg;
      end
   end

   assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN && !PREADY_OUT;
   assign rd_en = PSEL_IN && PENABLE_IN && !PWRITE_IN;
   assign center = (ctrl_reg.center_mode != `CMS_EDGE);

   // Two-flop sampled external trigger source selection and gating.
   always_comb begin
      case (opt_reg.ext_trigger_source_sel)
         `SRC_PCLK: trg_raw = 1'b1;
         `SRC_RC1K: trg_raw = pin_b_reg[5];
         `SRC_32K:  trg_raw = pin_b_reg[4];
         default:   trg_raw = pin_b_reg[3] & (pin_b_reg[2] | !opt_reg.clock_mask_enable);
      endcase
   end

   // Filters: a new level is accepted after it holds for the programmed samples.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         trg_filt_reg <= 1'b0;
         trg_run_reg  <= 4'h0;
         ch2_filt_reg <= 1'b0;
         ch2_run_reg  <= 4'h0;
      end else begin
         if ((trg_raw ^ smc_reg.ext_trigger_polarity) == trg_filt_reg) begin
            trg_run_reg <= 4'h0;
         end else if (trg_run_reg >= smc_reg.ext_trigger_filter) begin
            trg_filt_reg <= trg_raw ^ smc_reg.ext_trigger_polarity;
            trg_run_reg  <= 4'h0;
         end else begin
            trg_run_reg <= trg_run_reg + 4'h1;
         end
         if ((pin_b_reg[1] ^ chan2_polarity_reg) == ch2_filt_reg) begin
            ch2_run_reg <= 4'h0;
         end else if (ch2_run_reg >= chan2_input_filter_reg) begin
            ch2_filt_reg <= pin_b_reg[1] ^ chan2_polarity_reg;
            ch2_run_reg  <= 4'h0;
         end else begin
            ch2_run_reg <= ch2_run_reg + 4'h1;
         end
      end
   end

   assign trg_edge = trg_filt_reg && !trg_prev_reg;
   assign ch2_edge = ch2_filt_reg && !ch2_prev_reg;

   // Trigger prescaler: divide edges by 1, 2, 4 or 8.
   always_comb begin
      case (smc_reg.ext_trigger_prescale)
         `ETPS_DIV1: trg_tick = trg_edge;
         `ETPS_DIV2: trg_tick = trg_edge && trg_div_reg[0];
         `ETPS_DIV4: trg_tick = trg_edge && (trg_div_reg[1:0] == 2'h3);
         default:    trg_tick = trg_edge && (trg_div_reg == 3'h7);
      endcase
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         trg_prev_reg <= 1'b0;
         ch2_prev_reg <= 1'b0;
         trg_div_reg  <= 3'h0;
      end else begin
         trg_prev_reg <= trg_filt_reg;
         ch2_prev_reg <= ch2_filt_reg;
         if (trg_edge) begin
            trg_div_reg <= trg_div_reg + 3'h1;
         end
      end
   end

   // Prescaler clock source.
   always_comb begin
      if (smc_reg.ext_clock_enable) begin
         ck_psc = trg_tick;
      end else if (smc_reg.slave_mode_select == `SMS_EXT_CLOCK1) begin
         case (smc_reg.trigger_select)
            `TS_TRIG0: ck_psc = pin_b_reg[0];
            `TS_CHAN2: ck_psc = ch2_edge && (chan2_selection_reg == 2'h1);
            default:  ck_psc = trg_tick;
         endcase
      end else begin
         ck_psc = 1'b1;
      end
   end

   assign psc_limit = 16'((32'h1 << psc_act_reg) - 32'h1);
   assign psc_done  = (psc_cnt_reg == psc_limit);
   assign ck_cnt    = run_en_reg && ck_psc && psc_done;
   assign going_up  = center ? up_dir_reg : !ctrl_reg.count_direction;
   assign wrap      = ck_cnt && (center ? (up_dir_reg ? (cnt_reg >= arr_act_reg - 16'h1)
                                                      : (cnt_reg <= 16'h1))
                                         : (going_up ? (cnt_reg >= arr_act_reg) : (cnt_reg == 16'h0)));
   assign update_ev = (wrap || sw_update_reg) && !ctrl_reg.update_disable;
   assign arr_eff   = (update_ev || !ctrl_reg.auto_reload_buffer_enable) ? arr_buf_reg : arr_act_reg;

   // Counter enable follows the control bit one cycle later.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         run_en_reg <= 1'b0;
      end else begin
         run_en_reg <= ctrl_reg.counter_enable;
      end
   end

   // Prescaler counter.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         psc_cnt_reg <= 16'h0000;
      end else if (sw_update_reg || (run_en_reg && ck_psc && psc_done)) begin
         psc_cnt_reg <= 16'h0000;
      end else if (run_en_reg && ck_psc) begin
         psc_cnt_reg <= psc_cnt_reg + 16'h1;
      end
   end

   // Shadow registers.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         arr_act_reg <= `ARR_RESET;
         psc_act_reg <= 4'h0;
      end else begin
         arr_act_reg <= arr_eff;
         if (update_ev) begin
            psc_act_reg <= psc_buf_reg;
         end
      end
   end

   // Main counter and hardware direction.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         cnt_reg    <= 16'h0000;
         up_dir_reg <= 1'b1;
      end else if (sw_update_reg) begin
         if (center || going_up) begin
            cnt_reg    <= 16'h0000;
            up_dir_reg <= 1'b1;
         end else begin
            cnt_reg <= arr_eff;
         end
      end else if (ck_cnt) begin
         if (center) begin
            if (wrap && up_dir_reg) begin
               cnt_reg    <= arr_eff;
               up_dir_reg <= 1'b0;
            end else if (wrap) begin
               cnt_reg    <= 16'h0000;
               up_dir_reg <= 1'b1;
            end else begin
               cnt_reg <= up_dir_reg ? cnt_reg + 16'h1 : cnt_reg - 16'h1;
            end
         end else if (going_up) begin
            cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h1;
         end else begin
            cnt_reg <= wrap ? arr_eff : cnt_reg - 16'h1;
         end
      end
   end

   // Update generate bit is a self-clearing pulse.
   always_comb begin
      sw_update_next = wr_en && (PADDR_IN == `OFS_EVENT_GEN) && PWDATA_IN[0];
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         sw_update_reg <= 1'b0;
      end else begin
         sw_update_reg <= sw_update_next;
      end
   end

   // Flags: hardware set wins over a write-one clear.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         flags_reg <= 2'h0;
      end else begin
         if (update_ev && !(sw_update_reg && ctrl_reg.update_request_source)) begin
            flags_reg.update_irq_flag <= 1'b1;
         end else if (wr_en && PADDR_IN == `OFS_FLAGS && PWDATA_IN[0]) begin
            flags_reg.update_irq_flag <= 1'b0;
         end
         if (ck_cnt && smc_reg.slave_mode_select == `SMS_EXT_CLOCK1) begin
            flags_reg.trigger_irq_flag <= 1'b1;
         end else if (wr_en && PADDR_IN == `OFS_FLAGS && PWDATA_IN[1]) begin
            flags_reg.trigger_irq_flag <= 1'b0;
         end
      end
   end

   // Software-written configuration.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ctrl_reg               <= 7'h00;
         smc_reg                <= 14'h0000;
         opt_reg                <= 3'h0;
         chan2_selection_reg    <= 2'h0;
         chan2_input_filter_reg <= 4'h0;
         chan2_polarity_reg     <= 1'b0;
         arr_buf_reg            <= `ARR_RESET;
         psc_buf_reg            <= 4'h0;
      end else begin
         if (center) begin
            ctrl_reg.count_direction <= !up_dir_reg;
         end
         if (wr_en) begin
            case (PADDR_IN)
               `OFS_CONTROL: begin
                  ctrl_reg.counter_enable            <= PWDATA_IN[0];
                  ctrl_reg.update_disable            <= PWDATA_IN[1];
                  ctrl_reg.update_request_source     <= PWDATA_IN[2];
                  if (!center) begin
                     ctrl_reg.count_direction <= PWDATA_IN[4];
                  end
                  ctrl_reg.center_mode               <= PWDATA_IN[6:5];
                  ctrl_reg.auto_reload_buffer_enable <= PWDATA_IN[7];
               end
               `OFS_SLAVE_MODE:  smc_reg     <= PWDATA_IN[13:0];
               `OFS_OPTION:      opt_reg     <= PWDATA_IN[2:0];
               `OFS_PRESCALE:    psc_buf_reg <= PWDATA_IN[3:0];
               `OFS_AUTO_RELOAD: arr_buf_reg <= PWDATA_IN[15:0];
               `OFS_CHAN_MODE: begin
                  chan2_selection_reg    <= PWDATA_IN[9:8];
                  chan2_input_filter_reg <= PWDATA_IN[15:12];
               end
               `OFS_CHAN_ENABLE: chan2_polarity_reg <= PWDATA_IN[5];
               default: ;
            endcase
         end
      end
   end

   // Read mux.
   always_comb begin
      case (PADDR_IN)
         `OFS_CONTROL:     rdata_next = {24'h0, ctrl_reg.auto_reload_buffer_enable, ctrl_reg.center_mode,
                                         ctrl_reg.count_direction, 1'b0, ctrl_reg.update_request_source,
                                         ctrl_reg.update_disable, ctrl_reg.counter_enable};
         `OFS_SLAVE_MODE:  rdata_next = {18'h0, smc_reg};
         `OFS_OPTION:      rdata_next = {29'h0, opt_reg};
         `OFS_FLAGS:       rdata_next = {30'h0, flags_reg.trigger_irq_flag, flags_reg.update_irq_flag};
         `OFS_COUNT:       rdata_next = {16'h0, cnt_reg};
         `OFS_PRESCALE:    rdata_next = {28'h0, psc_buf_reg};
         `OFS_AUTO_RELOAD: rdata_next = {16'h0, arr_buf_reg};
         `OFS_CHAN_MODE:   rdata_next = {16'h0, chan2_input_filter_reg, 2'h0, chan2_selection_reg, 8'h0};
         `OFS_CHAN_ENABLE: rdata_next = {26'h0, chan2_polarity_reg, 5'h0};
         default:          rdata_next = 32'h0000_0000;
      endcase
   end

   // APB answer registered, one wait state per access.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         PRDATA_OUT       <= 32'h0000_0000;
         PREADY_OUT       <= 1'b0;
         PSLVERR_OUT      <= 1'b0;
         UPDATE_EVENT_OUT <= 1'b0;
         COUNT_OUT        <= 16'h0000;
      end else begin
         PREADY_OUT       <= PSEL_IN && PENABLE_IN && !PREADY_OUT;
         PSLVERR_OUT      <= PSEL_IN && PENABLE_IN && !PREADY_OUT && (PADDR_IN > `OFS_CHAN_ENABLE);
         PRDATA_OUT       <= (rd_en && !PREADY_OUT) ? rdata_next : 32'h0000_0000;
         UPDATE_EVENT_OUT <= update_ev;
         COUNT_OUT        <= cnt_reg;
      end
   end
endmodule

// >>> verification/timer_time_base_chk.sv
module timer_time_base_chk (
   // Watched ports.
   input wire logic                         SYS_CLK_IN,
   input wire logic                         ARST_N_IN,
   input wire logic                         PSEL_IN,
   input wire logic                         PENABLE_IN,
   input wire logic                         PWRITE_IN,
   input wire logic [11:0]                  PADDR_IN,
   input wire logic [31:0]                  PWDATA_IN,
   input wire logic [31:0]                  PRDATA_OUT,
   input wire logic                         PREADY_OUT,
   input wire logic                         PSLVERR_OUT,
   input wire tb_timer_pkg::timer_pins_type PINS_IN,
   input wire logic                         UPDATE_EVENT_OUT,
   input wire logic [15:0]                  COUNT_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        wr_take;
   logic [7:0]  ctl_reg;
   logic [15:0] arr_reg;
   logic        down;
   logic        center;
   default clocking cb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (!ARST_N_IN);
   assign wr_take = PSEL_IN && PENABLE_IN && PWRITE_IN && !PREADY_OUT;
   assign down    = ctl_reg[0] && ctl_reg[4] && ctl_reg[6:5] == 2'h0 && !ctl_reg[7];
   assign center  = ctl_reg[0] && ctl_reg[6:5] != 2'h0 && !ctl_reg[7];
   // Mirrors the control word as software last wrote it.
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         ctl_reg <= 8'h00;
      end else if (wr_take && PADDR_IN == 12'h000) begin
         ctl_reg <= PWDATA_IN[7:0];
      end
   end
   // Mirrors the auto-reload value as software last wrote it.
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         arr_reg <= 16'hFFFF;
      end else if (wr_take && PADDR_IN == 12'h01C) begin
         arr_reg <= PWDATA_IN[15:0];
      end
   end
   chk_ready_one_wait: assert property ($rose(PENABLE_IN) && PSEL_IN |=> PREADY_OUT)
      else $error("ready missing after one wait state");
   chk_ready_single: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("ready longer than one cycle");
   chk_ready_cause: assert property (PREADY_OUT |-> $past(PSEL_IN && PENABLE_IN))
      else $error("ready without access phase");
   chk_slverr_map: assert property (PREADY_OUT |-> PSLVERR_OUT == (PADDR_IN > 12'h024))
      else $error("slave error does not match address map");
   chk_rdata_idle: assert property (!PREADY_OUT || PSLVERR_OUT |-> PRDATA_OUT == 32'h00000000)
      else $error("read data not zero outside a good answer");
   chk_down_reload: assert property (down && UPDATE_EVENT_OUT |-> ##[0:3] COUNT_OUT == arr_reg)
      else $error("down counter not reloaded with auto-reload");
   chk_down_step: assert property (down && $past(down) && $changed(COUNT_OUT)
      |-> COUNT_OUT == $past(COUNT_OUT) - 16'h0001 || COUNT_OUT == arr_reg)
      else $error("down counter moved wrongly");
   chk_udis_quiet: assert property (ctl_reg[1] && $past(ctl_reg[1], 2) |-> !UPDATE_EVENT_OUT)
      else $error("update event while updates disabled");
   chk_center_bound: assert property (center && $past(center, 3) |-> COUNT_OUT <= arr_reg)
      else $error("center count above auto-reload");
endmodule
bind timer_time_base timer_time_base_chk i_chk (.SYS_CLK_IN, .ARST_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
   .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .PINS_IN, .UPDATE_EVENT_OUT, .COUNT_OUT);

// >>> verification/timer_pins_model.sv
module timer_pins_model (
   // Clock and requests.
   input  wire logic                   clk_in,
   input  wire logic                   chan2_go_in,
   input  wire logic                   pin_go_in,
   input  wire logic                   mask_in,
   // Pins.
   output tb_timer_pkg::timer_pins_type pins_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_reg = 2'h0;
   logic       wave_reg = 1'b0;
   // A square wave with one rising edge every eight clocks; it stands low when idle.
   always_ff @(posedge clk_in) begin
      if (!(chan2_go_in || pin_go_in)) begin
         phase_reg <= 2'h0;
         wave_reg  <= 1'b0;
      end else begin
         phase_reg <= phase_reg + 2'h1;
         if (phase_reg == 2'h3) begin
            wave_reg <= !wave_reg;
         end
      end
   end
   always_comb begin
      pins_out                 = 6'h00;
      pins_out.chan2_input     = wave_reg && chan2_go_in;
      pins_out.timer_clock_pin = wave_reg && pin_go_in;
      pins_out.timer_mask_pin  = mask_in;
      pins_out.rc1k            = wave_reg && chan2_go_in;
   end
endmodule

// >>> verification/timer_time_base_tb.sv
`include "tb_timer_cfg.svh"
module timer_time_base_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        update_ev;
   logic [15:0] count;
   logic        chan2_go = 1'b0;
   logic        pin_go = 1'b0;
   logic        mask = 1'b0;
   logic [31:0] rd;
   logic        err;
   int          fails = 0;
   int          check_count = 0;
   tb_timer_pkg::timer_pins_type pins;
   timer_time_base i_dut (.SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .PINS_IN(pins), .UPDATE_EVENT_OUT(update_ev), .COUNT_OUT(count));
   timer_pins_model i_pins (.clk_in(clk), .chan2_go_in(chan2_go), .pin_go_in(pin_go), .mask_in(mask),
      .pins_out(pins));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         fails++;
         print_verdict();
      end
      @(posedge clk);
   endtask
   task automatic count_up(input int cyc, output int k);
      k = 0;
      repeat (cyc) begin
         @(negedge clk);
         if (update_ev === 1'b1) begin
            k++;
         end
      end
      @(posedge clk);
   endtask
   task automatic edges(input logic ch2, input int n, output logic [15:0] d);
      logic [15:0] base;
      base = count;
      chan2_go <= ch2;
      pin_go   <= !ch2;
      repeat (8 * n) @(posedge clk);
      chan2_go <= 1'b0;
      pin_go   <= 1'b0;
      repeat (12) @(posedge clk);
      d = count - base;
   endtask
   task automatic test_down();
      int k;
      apb(1'b0, 12'h040, 32'h0);
      check(rd, 32'h0);
      check(err, 1'b1);
      apb(1'b0, `OFS_AUTO_RELOAD, 32'h0);
      check(rd, 32'h0000FFFF);
      apb(1'b1, `OFS_AUTO_RELOAD, 32'h5);
      apb(1'b1, `OFS_CONTROL, 32'h11);
      count_up(60, k);
      check(k, 10);
      apb(1'b0, `OFS_FLAGS, 32'h0);
      check(rd[0], 1'b1);
      apb(1'b1, `OFS_CONTROL, 32'h91);
      apb(1'b1, `OFS_AUTO_RELOAD, 32'h3);
      repeat (8) @(posedge clk);
      count_up(40, k);
      check(k, 10);
      $display("down test done");
   endtask
   task automatic test_psc();
      int k;
      apb(1'b1, `OFS_CONTROL, 32'h14);
      apb(1'b1, `OFS_AUTO_RELOAD, 32'h5);
      apb(1'b1, `OFS_PRESCALE, 32'h2);
      apb(1'b1, `OFS_FLAGS, 32'h3);
      apb(1'b1, `OFS_EVENT_GEN, 32'h1);
      repeat (2) @(posedge clk);
      check(count, 16'h5);
      apb(1'b0, `OFS_FLAGS, 32'h0);
      check(rd[0], 1'b0);
      apb(1'b0, `OFS_EVENT_GEN, 32'h0);
      check(rd[0], 1'b0);
      apb(1'b1, `OFS_CONTROL, 32'h15);
      count_up(96, k);
      check(k, 4);
      apb(1'b1, `OFS_CONTROL, 32'h17);
      count_up(100, k);
      check(k, 0);
      $display("prescale test done");
   endtask
   task automatic test_center();
      int k;
      logic [1:0] seen;
      seen = 2'h0;
      apb(1'b1, `OFS_PRESCALE, 32'h0);
      apb(1'b1, `OFS_CONTROL, 32'h21);
      apb(1'b1, `OFS_AUTO_RELOAD, 32'h6);
      apb(1'b1, `OFS_EVENT_GEN, 32'h1);
      repeat (4) @(posedge clk);
      count_up(60, k);
      check(k, 10);
      repeat (8) begin
         apb(1'b0, `OFS_CONTROL, 32'h0);
         seen[rd[4]] = 1'b1;
      end
      check(seen, 2'h3);
      $display("center test done");
   endtask
   task automatic test_ext1();
      logic [15:0] d;
      apb(1'b1, `OFS_CONTROL, 32'h0);
      apb(1'b1, `OFS_AUTO_RELOAD, 32'hFFFF);
      apb(1'b1, `OFS_CHAN_MODE, 32'h100);
      apb(1'b1, `OFS_CHAN_ENABLE, 32'h0);
      apb(1'b1, `OFS_SLAVE_MODE, 32'h37);
      apb(1'b1, `OFS_CONTROL, 32'h1);
      apb(1'b1, `OFS_FLAGS, 32'h3);
      edges(1'b1, 5, d);
      check(d, 16'h5);
      apb(1'b0, `OFS_FLAGS, 32'h0);
      check(rd[1], 1'b1);
      $display("channel clock test done");
   endtask
   task automatic test_ext2();
      logic [15:0] d;
      apb(1'b1, `OFS_OPTION, 32'h7);
      mask <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `OFS_SLAVE_MODE, 32'h1000 | 32'(i) << 10);
         edges(1'b0, 8, d);
         check(d, 16'h8 >> i);
      end
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, `OFS_OPTION, 32'h4 | 32'(s));
         repeat (12) @(posedge clk);
         edges(1'b0, 8, d);
         check(d, 16'h0);
      end
      apb(1'b1, `OFS_OPTION, 32'h7);
      mask <= 1'b0;
      edges(1'b0, 8, d);
      check(d, 16'h0);
      apb(1'b1, `OFS_OPTION, 32'h5);
      edges(1'b1, 8, d);
      check(d, 16'h1);
      $display("trigger clock test done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      test_down();
      test_psc();
      test_center();
      test_ext1();
      test_ext2();
      print_verdict();
   end
endmodule
